// File: verilog/iws_pkg.sv
// constants and state types for the interrupt and wake status block
package iws_pkg;
    localparam int unsigned NUM_SRC = 4;
    localparam int unsigned VEC_W = 12;
    // source bit positions in the flag and mask registers
    localparam int unsigned SRC_TC_BIT = 0;
    localparam int unsigned SRC_EXT_BIT = 1;
    localparam int unsigned SRC_SPI_BIT = 2;
    localparam int unsigned SRC_T1_BIT = 3;
    // fetch addresses
    localparam logic [VEC_W-1:0] HW_VECTOR = 12'h001;
    localparam logic [VEC_W-1:0] SW_VECTOR = 12'h002;
    // values after any reset
    localparam logic [NUM_SRC-1:0] FLAG_RST = 4'h0;
    localparam logic [NUM_SRC-1:0] MASK_RST = 4'h0;
    localparam logic GIE_RST = 1'b0;
    localparam logic [VEC_W-1:0] VEC_RST = 12'h000;
    // time-out and power-down flags after power-on
    localparam logic TO_POR = 1'b1;
    localparam logic PD_POR = 1'b1;

    typedef enum logic [1:0] {
        IWS_RUN,
        IWS_FIRST_SLEEP,
        IWS_SECOND_SLEEP
    } iws_mode_type;

    typedef struct packed {
        logic to_flag;
        logic pd_flag;
    } iws_tp_type;

    typedef struct packed {
        iws_mode_type mode;
        logic [NUM_SRC-1:0] flags;
        logic [NUM_SRC-1:0] mask;
        logic gie;
        logic sw_pend;
        logic vec_req;
        logic [VEC_W-1:0] vec_addr;
        logic [NUM_SRC-1:0] flag_rd;
        logic core_rst;
        logic wake;
        logic asleep;
    } iws_core_type;
endpackage

// File: verilog/iws_status_flags.sv
// time-out and power-down status flags
`timescale 1ns/100ps
`default_nettype none
module iws_status_flags
    import iws_pkg::*;
(
    input wire logic sys_clk, // core instruction clock
    input wire logic nrst, // power-on reset, active low
    input wire logic ev_wdt_run, // watchdog reset while running
    input wire logic ev_wdt_s1, // watchdog wake from first sleep mode
    input wire logic ev_wdt_s2, // watchdog wake from second sleep mode
    input wire logic ev_wd_clear, // watchdog-clear instruction
    input wire logic ev_sleep, // enter-sleep instruction
    output logic to_flag, // time-out flag
    output logic pd_flag // power-down flag
);
    iws_tp_type st_r;
    iws_tp_type st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (ev_wd_clear)
        begin
            st_nxt.to_flag = 1'b1;
            st_nxt.pd_flag = 1'b1;
        end
        if (ev_sleep)
        begin
            st_nxt.to_flag = 1'b1;
            st_nxt.pd_flag = 1'b0;
        end
        // power-down keeps its value on these two
        if (ev_wdt_run || ev_wdt_s2)
        begin
            st_nxt.to_flag = 1'b0;
        end
        if (ev_wdt_s1)
        begin
            st_nxt.to_flag = 1'b0;
            st_nxt.pd_flag = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r.to_flag <= TO_POR;
            st_r.pd_flag <= PD_POR;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign to_flag = st_r.to_flag;
    assign pd_flag = st_r.pd_flag;
endmodule
`default_nettype wire

// File: verilog/iws_top.sv
// interrupt flags, mask, global enable, vectoring and reset/wake cause
//
// What this block does
// - Reset comes only from power-on (nrst) or watchdog expiry.
// - Power-on sets time-out and power-down flags to one.
// - Watchdog reset while running clears time-out, keeps power-down.
// - Watchdog wake from first sleep mode clears both status flags.
// - Watchdog wake from second sleep mode clears time-out, keeps power-down.
// - Pin-change wake from second sleep mode leaves both status flags alone.
// - Watchdog-clear sets both; enter-sleep sets time-out, clears power-down; expiry clears time-out.
// - Four sources: timer overflow, external pin, serial transfer done, timer1 match.
// - Requests latch into a flag register; a per-source mask register gates read-back and vectoring.
// - Global enable is set by the enable instruction, cleared by the disable instruction.
// - An enabled peripheral interrupt fetches next from address 001.
// - Flags set on their event regardless of mask or global enable.
// - Flag register reads return flags AND mask.
// - Return-from-interrupt sets the global enable like the enable instruction.
// - Software interrupt with enable set fetches next from address 002 when no unmasked flag is pending.
// - Flags stay set until software clears them or a power-on or watchdog reset clears them.
`timescale 1ns/100ps
`default_nettype none
module iws_top
    import iws_pkg::*;
(
    input wire logic sys_clk, // core instruction clock, 125 MHz
    input wire logic nrst, // power-on reset, active low
    input wire logic wdt_expire, // watchdog timer expiry pulse
    input wire logic pin_change, // port pin-change wake event
    input wire logic evt_timer_ovf, // timer_counter overflow pulse
    input wire logic evt_ext_int, // external interrupt pin event pulse
    input wire logic evt_spi_done, // serial transfer done pulse
    input wire logic evt_t1_match, // timer1 compare match pulse
    input wire logic global_irq_on_instr, // enable-interrupt instruction strobe
    input wire logic global_irq_off_instr, // disable-interrupt instruction strobe
    input wire logic return_from_irq_instr, // return-from-interrupt strobe
    input wire logic soft_irq_instr, // software interrupt instruction strobe
    input wire logic enter_sleep_instr, // enter-sleep instruction strobe
    input wire logic sleep_mode_sel, // 0 first_sleep_mode, 1 second_sleep_mode
    input wire logic watchdog_clear_instr, // watchdog-clear instruction strobe
    input wire logic flag_wr, // software write of interrupt_flag_register
    input wire logic [NUM_SRC-1:0] flag_wdata, // value written to the flags
    input wire logic mask_wr, // software write of interrupt_mask_register
    input wire logic [NUM_SRC-1:0] mask_wdata, // value written to the mask
    output logic [NUM_SRC-1:0] flag_rdata, // flags AND mask, as software reads them
    output logic [NUM_SRC-1:0] mask_rdata, // interrupt_mask_register contents
    output logic global_irq_en, // global interrupt enable
    output logic vec_req, // one-cycle request to fetch from vec_addr
    output logic [VEC_W-1:0] vec_addr, // fetch address of the last vector
    output logic core_reset, // one-cycle watchdog reset of the core
    output logic wake, // one-cycle wake pulse after a pin change in second sleep mode
    output logic sleeping, // core is in a sleep mode
    output logic timeout_flag, // time-out status flag
    output logic powerdown_flag // power-down status flag
);
    iws_core_type st_r;
    iws_core_type st_nxt;

    logic [NUM_SRC-1:0] src_evt;
    logic in_run;
    logic wdt_run;
    logic wdt_s1;
    logic wdt_s2;
    logic pin_s2;
    logic do_sleep;
    logic do_wd_clear;

    // unmasked pending sources; used for both read-back and vector decision
    function automatic logic [NUM_SRC-1:0] gated(input logic [NUM_SRC-1:0] f,
                                                 input logic [NUM_SRC-1:0] m);
        gated = f & m;
    endfunction

    always_comb
    begin
        src_evt = '0;
        src_evt[SRC_TC_BIT] = evt_timer_ovf;
        src_evt[SRC_EXT_BIT] = evt_ext_int;
        src_evt[SRC_SPI_BIT] = evt_spi_done;
        src_evt[SRC_T1_BIT] = evt_t1_match;
    end

    assign in_run = (st_r.mode == IWS_RUN);
    // watchdog expiry is a reset in every mode; its flag effect depends on the mode
    assign wdt_run = wdt_expire && (st_r.mode == IWS_RUN);
    assign wdt_s1 = wdt_expire && (st_r.mode == IWS_FIRST_SLEEP);
    assign wdt_s2 = wdt_expire && (st_r.mode == IWS_SECOND_SLEEP);
    assign pin_s2 = pin_change && !wdt_expire && (st_r.mode == IWS_SECOND_SLEEP);
    // instructions only execute while the core runs and no reset lands
    assign do_sleep = enter_sleep_instr && in_run && !wdt_expire;
    assign do_wd_clear = watchdog_clear_instr && in_run && !wdt_expire;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.vec_req = 1'b0;
        st_nxt.core_rst = 1'b0;
        st_nxt.wake = 1'b0;

        // software write first, so an event in the same cycle still sets its flag
        if (flag_wr && in_run)
        begin
            st_nxt.flags = flag_wdata;
        end
        st_nxt.flags = st_nxt.flags | src_evt;
        if (mask_wr && in_run)
        begin
            st_nxt.mask = mask_wdata;
        end

        if (in_run)
        begin
            if (global_irq_off_instr)
            begin
                st_nxt.gie = 1'b0;
            end
            if (global_irq_on_instr || return_from_irq_instr)
            begin
                st_nxt.gie = 1'b1;
            end
            if (soft_irq_instr)
            begin
                st_nxt.sw_pend = 1'b1;
            end
            // a vector needs the enable as it stood; the hardware vector wins a tie
            if (st_r.gie && (|gated(st_r.flags, st_r.mask)))
            begin
                st_nxt.vec_req = 1'b1;
                st_nxt.vec_addr = HW_VECTOR;
                st_nxt.gie = 1'b0;
            end
            else if (st_r.gie && (st_r.sw_pend || soft_irq_instr))
            begin
                st_nxt.vec_req = 1'b1;
                st_nxt.vec_addr = SW_VECTOR;
                st_nxt.gie = 1'b0;
                st_nxt.sw_pend = 1'b0;
            end
            if (do_sleep)
            begin
                st_nxt.mode = sleep_mode_sel ? IWS_SECOND_SLEEP : IWS_FIRST_SLEEP;
            end
        end

        unique case (st_r.mode)
            IWS_RUN:
            begin
            end
            IWS_FIRST_SLEEP:
            begin
            end
            IWS_SECOND_SLEEP:
            begin
                if (pin_s2)
                begin
                    st_nxt.mode = IWS_RUN;
                    st_nxt.wake = 1'b1;
                end
            end
            default:
            begin
                st_nxt.mode = IWS_RUN;
            end
        endcase

        // watchdog reset overrides everything; event flags restart from zero
        if (wdt_expire)
        begin
            st_nxt.mode = IWS_RUN;
            st_nxt.core_rst = 1'b1;
            st_nxt.flags = FLAG_RST;
            st_nxt.mask = MASK_RST;
            st_nxt.gie = GIE_RST;
            st_nxt.sw_pend = 1'b0;
            st_nxt.vec_req = 1'b0;
            st_nxt.vec_addr = VEC_RST;
        end

        st_nxt.flag_rd = gated(st_nxt.flags, st_nxt.mask);
        // kept as its own flop so the sleeping output is glitch free
        st_nxt.asleep = (st_nxt.mode != IWS_RUN);
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r.mode <= IWS_RUN;
            st_r.flags <= FLAG_RST;
            st_r.mask <= MASK_RST;
            st_r.gie <= GIE_RST;
            st_r.sw_pend <= 1'b0;
            st_r.vec_req <= 1'b0;
            st_r.vec_addr <= VEC_RST;
            st_r.flag_rd <= FLAG_RST;
            st_r.core_rst <= 1'b0;
            st_r.wake <= 1'b0;
            st_r.asleep <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    iws_status_flags u_status
    (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .ev_wdt_run(wdt_run),
        .ev_wdt_s1(wdt_s1),
        .ev_wdt_s2(wdt_s2),
        .ev_wd_clear(do_wd_clear),
        .ev_sleep(do_sleep),
        .to_flag(timeout_flag),
        .pd_flag(powerdown_flag)
    );

    assign flag_rdata = st_r.flag_rd;
    assign mask_rdata = st_r.mask;
    assign global_irq_en = st_r.gie;
    assign vec_req = st_r.vec_req;
    assign vec_addr = st_r.vec_addr;
    assign core_reset = st_r.core_rst;
    assign wake = st_r.wake;
    assign sleeping = st_r.asleep;
endmodule
`default_nettype wire

// File: verification/iws_src_model.sv
// model of the peripheral request sources that feed the event inputs
`timescale 1ns/100ps
`default_nettype none
module iws_src_model
    import iws_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic nrst, // reset
    input wire logic [NUM_SRC-1:0] req, // requests from the bench
    output logic [NUM_SRC-1:0] evt // one-cycle event pulses
);
    logic [NUM_SRC-1:0] req_q;

    // a held request gives one pulse only, as a real overflow or match does
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            evt <= '0;
            req_q <= '0;
        end
        else
        begin
            evt <= req & ~req_q;
            req_q <= req;
        end
    end
endmodule
`default_nettype wire

// File: verification/iws_top_assertions.sv
// concurrent checks on the ports of the interrupt and wake status top
`timescale 1ns/100ps
`default_nettype none
module iws_top_chk
    import iws_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic nrst, // reset
    input wire logic wdt_expire, // expiry
    input wire logic global_irq_on_instr, // on
    input wire logic global_irq_off_instr, // off
    input wire logic return_from_irq_instr, // return
    input wire logic enter_sleep_instr, // sleep
    input wire logic watchdog_clear_instr, // clear
    input wire logic flag_wr, // flag write
    input wire logic mask_wr, // mask write
    input wire logic [NUM_SRC-1:0] flag_rdata, // flags
    input wire logic global_irq_en, // enable
    input wire logic vec_req, // vector
    input wire logic [VEC_W-1:0] vec_addr, // address
    input wire logic core_reset, // core reset
    input wire logic wake, // wake
    input wire logic sleeping, // asleep
    input wire logic timeout_flag, // time-out
    input wire logic powerdown_flag // power-down
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // instructions only count while awake and not overtaken by an expiry
    sequence s_taken(ins);
        ins && !sleeping && !wdt_expire;
    endsequence
    property p_hw_vec;
        |flag_rdata && global_irq_en && !sleeping && !wdt_expire |=> vec_req && vec_addr == HW_VECTOR;
    endproperty
    a_hw_vec: assert property (p_hw_vec) else $error("hardware vector missing");
    property p_vec_gie;
        vec_req |-> $past(global_irq_en) && !global_irq_en;
    endproperty
    a_vec_gie: assert property (p_vec_gie) else $error("vector without enable");
    property p_wdt_run;
        wdt_expire && !sleeping |=> core_reset && !timeout_flag && powerdown_flag == $past(powerdown_flag);
    endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("watchdog reset status wrong");
    property p_sleep_entry;
        s_taken(enter_sleep_instr) |=> sleeping && timeout_flag && !powerdown_flag;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry status wrong");
    property p_wd_clear;
        s_taken(watchdog_clear_instr && !enter_sleep_instr) |=> timeout_flag && powerdown_flag;
    endproperty
    a_wd_clear: assert property (p_wd_clear) else $error("watchdog clear status wrong");
    // a vector taken in the same cycle clears the enable again
    property p_on;
        s_taken(global_irq_on_instr || return_from_irq_instr) |=> global_irq_en ^ vec_req;
    endproperty
    a_on: assert property (p_on) else $error("enable not set");
    property p_off;
        s_taken(global_irq_off_instr && !global_irq_on_instr && !return_from_irq_instr) |=> !global_irq_en;
    endproperty
    a_off: assert property (p_off) else $error("enable not cleared");
    property p_wake;
        wake |-> !sleeping && $stable(timeout_flag) && $stable(powerdown_flag);
    endproperty
    a_wake: assert property (p_wake) else $error("pin wake changed status");
    property p_hold;
        !flag_wr && !mask_wr && !wdt_expire |=> (flag_rdata & $past(flag_rdata)) == $past(flag_rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped without write");
endmodule
bind iws_top iws_top_chk i_iws_top_chk (.sys_clk, .nrst, .wdt_expire, .global_irq_on_instr,
    .global_irq_off_instr, .return_from_irq_instr, .enter_sleep_instr, .watchdog_clear_instr,
    .flag_wr, .mask_wr, .flag_rdata, .global_irq_en, .vec_req, .vec_addr, .core_reset, .wake,
    .sleeping, .timeout_flag, .powerdown_flag);
`default_nettype wire

// File: verification/tb_interrupt_and_wake_status.sv
// self-checking bench for the interrupt and wake status block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_interrupt_and_wake_status;
    import iws_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic sleep_mode_sel = 1'b0;
    logic [9:0] stb = '0;
    logic [NUM_SRC-1:0] req = '0;
    logic [NUM_SRC-1:0] wdata = '0;
    logic [NUM_SRC-1:0] evt, flag_rdata, mask_rdata, m;
    logic global_irq_en, vec_req, core_reset, wake, sleeping, timeout_flag, powerdown_flag;
    logic [VEC_W-1:0] vec_addr, exp_a;
    logic [VEC_W-1:0] exp_q[$];
    logic [31:0] seed = 32'h0000e452;
    int err_total = 0;
    int checks = 0;
    iws_src_model i_iws_src_model (.sys_clk, .nrst, .req, .evt);
    iws_top i_iws_top (.sys_clk, .nrst, .wdt_expire(stb[6]), .pin_change(stb[7]), .evt_timer_ovf(evt[0]),
        .evt_ext_int(evt[1]), .evt_spi_done(evt[2]), .evt_t1_match(evt[3]), .global_irq_on_instr(stb[0]),
        .global_irq_off_instr(stb[1]), .return_from_irq_instr(stb[2]), .soft_irq_instr(stb[3]),
        .enter_sleep_instr(stb[4]), .sleep_mode_sel, .watchdog_clear_instr(stb[5]), .flag_wr(stb[8]),
        .flag_wdata(wdata), .mask_wr(stb[9]), .mask_wdata(wdata), .flag_rdata, .mask_rdata, .global_irq_en,
        .vec_req, .vec_addr, .core_reset, .wake, .sleeping, .timeout_flag, .powerdown_flag);
    initial
    begin
        forever #4 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // one strobe for one cycle; data and sleep select ride along with it
    task automatic pulse(input int b, input logic [NUM_SRC-1:0] v);
        @(posedge sys_clk);
        stb[b] <= 1'b1;
        wdata <= v;
        sleep_mode_sel <= v[0];
        @(posedge sys_clk);
        stb <= '0;
        #1;
    endtask
    task automatic events(input logic [NUM_SRC-1:0] r);
        @(posedge sys_clk);
        req <= r;
        @(posedge sys_clk);
        req <= '0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic drain();
        repeat (8)
        begin
            if (exp_q.size() != 0) @(posedge sys_clk);
        end
        #1;
        `CHK("vector queue empty", 0, exp_q.size())
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // every vector seen must have been announced by the driver; looked at mid-cycle
    always @(negedge sys_clk)
    begin
        if (vec_req === 1'b1)
        begin
            if (exp_q.size() == 0)
            begin
                `CHK("unexpected vector", 1'b0, 1'b1)
            end
            else
            begin
                exp_a = exp_q.pop_front();
                `CHK("vec_addr", exp_a, vec_addr)
            end
        end
    end
    initial
    begin
        #40000;
        err_total++;
        end_of_test();
    end
    initial
    begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
        `CHK("timeout after power-on", 1'b1, timeout_flag)
        `CHK("powerdown after power-on", 1'b1, powerdown_flag)
        m = 4'(rnd()) | 4'h1;
        pulse(9, m);
        `CHK("mask", m, mask_rdata)
        events(4'hf);
        `CHK("masked flag read", m, flag_rdata)
        pulse(9, 4'hf);
        `CHK("flags set while disabled", 4'hf, flag_rdata)
        exp_q.push_back(HW_VECTOR);
        pulse(0, 4'h0);
        `CHK("enable on", 1'b1, global_irq_en)
        drain();
        `CHK("enable after vector", 1'b0, global_irq_en)
        pulse(8, 4'h0);
        `CHK("flags cleared", 4'h0, flag_rdata)
        pulse(3, 4'h0);
        repeat (3) @(posedge sys_clk);
        exp_q.push_back(SW_VECTOR);
        pulse(2, 4'h0);
        `CHK("enable after return", 1'b1, global_irq_en)
        drain();
        pulse(0, 4'h0);
        pulse(1, 4'h0);
        `CHK("enable off", 1'b0, global_irq_en)
        pulse(6, 4'h0);
        `CHK("core reset", 1'b1, core_reset)
        `CHK("mask after expiry", 4'h0, mask_rdata)
        `CHK("timeout after expiry", 1'b0, timeout_flag)
        `CHK("powerdown kept", 1'b1, powerdown_flag)
        pulse(4, 4'h1);
        `CHK("asleep", 1'b1, sleeping)
        `CHK("timeout after sleep", 1'b1, timeout_flag)
        `CHK("powerdown after sleep", 1'b0, powerdown_flag)
        pulse(7, 4'h0);
        `CHK("wake pulse", 1'b1, wake)
        `CHK("awake after pin wake", 1'b0, sleeping)
        `CHK("timeout on pin wake", 1'b1, timeout_flag)
        `CHK("powerdown on pin wake", 1'b0, powerdown_flag)
        for (int i = 0; i < 2; i++)
        begin
            pulse(4, 4'(i));
            pulse(6, 4'h0);
            `CHK("awake after expiry wake", 1'b0, sleeping)
            `CHK("timeout on expiry wake", 1'b0, timeout_flag)
            `CHK("powerdown on expiry wake", 1'b0, powerdown_flag)
        end
        // both flags are low here, so the clear shows on each of them
        pulse(5, 4'h0);
        `CHK("timeout after clear", 1'b1, timeout_flag)
        `CHK("powerdown after clear", 1'b1, powerdown_flag)
        end_of_test();
    end
endmodule
`default_nettype wire
